// *** dv/cle_enc_model.sv ***
// Behavioural quadrature encoder standing in for the external ABN encoder.
// Phases change just after a falling edge of ref_clk and then hold several cycles.
`timescale 1ns/10ps
module cle_enc_model
(
	input wire logic ref_clk,
	output logic enc_a,
	output logic enc_b
);
	logic [1:0] idx = 2'h0;
	// Gray order keeps one phase change per step; the bench compares magnitudes only
	assign enc_a = idx[1];
	assign enc_b = idx[1] ^ idx[0];

	task automatic step(input logic fwd);
		@(negedge ref_clk);
		idx = fwd ? idx + 2'h1 : idx - 2'h1;
		repeat (3) @(negedge ref_clk);
	endtask
endmodule

// *** dv/cle_top_sva.sv ***
// Port-level assertions for cle_top, bound at the foot of this file.
// Assumes one clock domain, ref_clk, with synchronous active-low rst_n.
`timescale 1ns/10ps
`include "cle_map.svh"
module cle_top_sva
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic set_axis_parameter_cmd,
	input wire logic get_axis_parameter_cmd,
	input wire logic [7:0] param_num,
	input wire logic [31:0] param_wdata,
	input wire logic ref_search_done,
	input wire logic [31:0] actual_speed,
	input wire logic [31:0] param_rdata,
	input wire logic param_rvalid,
	input wire logic motor_stop,
	input wire logic deviation_stop,
	input wire logic stall_stop,
	input wire logic init_done,
	input wire logic [9:0] commut_angle,
	input wire logic [7:0] current_scale
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	sequence cl_on;
		set_axis_parameter_cmd && param_num == 8'h81 && param_wdata[0];
	endsequence
	sequence pos_read;
		get_axis_parameter_cmd && param_num == 8'hD1;
	endsequence
	logic cl_wr;
	logic init_wait_on;
	logic [15:0] init_wait;

	assign cl_wr = set_axis_parameter_cmd && param_num == 8'h81;

	// Cycles since closed loop was switched on; held once init must be over
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			init_wait <= 16'h0000;
			init_wait_on <= 1'b0;
		end
		else if (cl_wr)
		begin
			init_wait <= 16'h0000;
			init_wait_on <= param_wdata[0];
		end
		else if (init_wait_on && init_wait != `CLE_INIT_CYCLES + 16'h0001)
		begin
			init_wait <= init_wait + 16'h0001;
		end
	end

	AST_RVALID_NEXT: assert property (get_axis_parameter_cmd |=> param_rvalid)
		else $error("read strobe not answered next cycle");
	AST_RVALID_PULSE: assert property (!get_axis_parameter_cmd |=> !param_rvalid)
		else $error("read valid without a read strobe");
	AST_UNMAPPED_ZERO: assert property (get_axis_parameter_cmd && param_num == 8'h00 |=> param_rdata == 32'h0)
		else $error("unmapped parameter read not zero");
	AST_STOP_OR: assert property (motor_stop == (deviation_stop || stall_stop))
		else $error("motor stop not the or of its causes");
	AST_STALL_HOLD: assert property (stall_stop && !cl_wr |=> stall_stop)
		else $error("stall stop released without enable write");
	AST_DEV_HOLD: assert property (deviation_stop && !cl_wr |=> deviation_stop)
		else $error("deviation stop released without enable write");
	AST_STALL_SPEED: assert property ($rose(stall_stop) |-> $past(actual_speed) != 32'h0)
		else $error("stall stop at standstill");
	AST_INIT_WAIT: assert property (cl_on |=> !init_done)
		else $error("init done not cleared by enable");
	AST_INIT_EARLY: assert property (init_wait_on && init_wait < `CLE_INIT_CYCLES + 16'h0001 |-> !init_done)
		else $error("init done too early");
	AST_INIT_LATE: assert property (init_wait_on && init_wait == `CLE_INIT_CYCLES + 16'h0001 |-> init_done)
		else $error("init done too late");
	AST_REF_CLEAR: assert property (ref_search_done ##2 pos_read |=> param_rdata == 32'h0)
		else $error("encoder position not cleared by reference search");
	AST_COMMUT_RANGE: assert property (commut_angle <= 10'h200)
		else $error("commutation angle beyond 180");
	AST_COMMUT_IDLE: assert property (!init_done |=> commut_angle == 10'h100)
		else $error("commutation angle not 90 outside closed loop");
	AST_CURRENT_STEP: assert property ($changed(current_scale) |->
		current_scale == $past(current_scale) + 8'h01 || current_scale == $past(current_scale) - 8'h01)
		else $error("current scale jumped more than one step");
endmodule

bind cle_top cle_top_sva u_sva
(
	.ref_clk, .rst_n, .set_axis_parameter_cmd, .get_axis_parameter_cmd, .param_num, .param_wdata,
	.ref_search_done, .actual_speed, .param_rdata, .param_rvalid, .motor_stop, .deviation_stop,
	.stall_stop, .init_done, .commut_angle, .current_scale
);

// *** dv/cle_top_tb.sv ***
// Self-checking bench for cle_top with a behavioural encoder on the phase inputs.
// Assumes the checker is bound from its own file; all inputs change at falling edges.
`timescale 1ns/10ps
module cle_top_tb;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic set_axis_parameter_cmd = 1'b0;
	logic get_axis_parameter_cmd = 1'b0;
	logic [7:0] param_num = 8'h00;
	logic [31:0] param_wdata = 32'h0;
	logic ref_search_done = 1'b0;
	logic signed [31:0] target_pos = 32'sh0;
	logic signed [31:0] ramp_pos = 32'sh0;
	logic [31:0] actual_speed = 32'h0;
	logic [9:0] drive_angle = 10'h000;
	logic [9:0] rotor_angle = 10'h000;
	logic [9:0] load_value = 10'h3FF;
	logic enc_a, enc_b, param_rvalid, motor_stop, deviation_stop, stall_stop;
	logic target_reached, catch_up, init_done;
	logic [31:0] param_rdata;
	logic [9:0] commut_angle;
	logic [7:0] current_scale;
	logic [31:0] rd;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;

	cle_enc_model u_enc (.ref_clk, .enc_a, .enc_b);
	cle_top u_dut (.ref_clk, .rst_n, .set_axis_parameter_cmd, .get_axis_parameter_cmd, .param_num,
		.param_wdata, .enc_a, .enc_b, .ref_search_done, .target_pos, .ramp_pos, .actual_speed,
		.drive_angle, .rotor_angle, .load_value, .param_rdata, .param_rvalid, .motor_stop,
		.deviation_stop, .stall_stop, .target_reached, .catch_up, .init_done, .commut_angle,
		.current_scale);

	initial
	begin
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Hang guard: the whole run needs about 2700 cycles
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 10000)
		begin
			miscompares++;
			complete_run;
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic wr(input logic [7:0] n, input logic [31:0] d);
		@(negedge ref_clk);
		set_axis_parameter_cmd = 1'b1;
		param_num = n;
		param_wdata = d;
		@(negedge ref_clk);
		set_axis_parameter_cmd = 1'b0;
	endtask

	// Strobe taken at one edge; answer stands until the next
	task automatic rdp(input logic [7:0] n, output logic [31:0] d);
		@(negedge ref_clk);
		get_axis_parameter_cmd = 1'b1;
		param_num = n;
		@(negedge ref_clk);
		get_axis_parameter_cmd = 1'b0;
		chk("read valid", 32'h1, {31'h0, param_rvalid});
		d = param_rdata;
	endtask

	task automatic t_defaults;
		logic [7:0] nums [7] = '{8'hCA, 8'hD2, 8'h6F, 8'h71, 8'h72, 8'h86, 8'hD4};
		logic [31:0] exps [7] = '{32'hC8, 32'h190, 32'hFF, 32'h0, 32'hFF, 32'h64, 32'h0};
		chk("reset angle", 32'h100, {22'h0, commut_angle});
		for (int i = 0; i < 7; i++)
		begin
			rdp(nums[i], rd);
			chk("default", exps[i], rd);
		end
		wr(8'h00, 32'h1234_5678);
		rdp(8'h00, rd);
		chk("unmapped", 32'h0, rd);
		wr(8'h85, 32'h1);
		rdp(8'h85, rd);
		chk("status read only", 32'h0, rd);
		$display("test defaults done");
	endtask

	task automatic t_encoder;
		repeat (4) u_enc.step(1'b1);
		cyc(600);
		rdp(8'hD1, rd);
		if (rd[31])
			rd = -rd;
		chk("forward scaled", 32'h200, rd);
		repeat (4) u_enc.step(1'b0);
		cyc(600);
		rdp(8'hD1, rd);
		chk("back to origin", 32'h0, rd);
		// One microstep per count when counts match microsteps per turn
		wr(8'hD2, 32'h0000_C800);
		repeat (3) u_enc.step(1'b1);
		cyc(10);
		rdp(8'hD1, rd);
		if (rd[31])
			rd = -rd;
		chk("rescaled", 32'h3, rd);
		wr(8'hD2, 32'h190);
		wr(8'hD1, 32'h3E8);
		cyc(1);
		rdp(8'hD1, rd);
		chk("position load", 32'h3E8, rd);
		ref_search_done = 1'b1;
		cyc(1);
		ref_search_done = 1'b0;
		rdp(8'hD1, rd);
		chk("reference clear", 32'h0, rd);
		$display("test encoder done");
	endtask

	task automatic t_loop;
		int n;
		drive_angle = 10'h080;
		wr(8'h81, 32'h1);
		chk("init early", 32'h0, {31'h0, init_done});
		n = 0;
		rd = 32'h0;
		while (rd === 32'h0 && n < 1200)
		begin
			rdp(8'h85, rd);
			n++;
		end
		chk("init status", 32'h1, rd);
		chk("init length", 32'h1, {31'h0, n >= 500});
		target_pos = 32'sd50;
		ramp_pos = 32'sd50;
		cyc(10);
		chk("inside window", 32'h1, {31'h0, target_reached});
		chk("no catch up", 32'h0, {31'h0, catch_up});
		chk("tracking angle", 32'h080, {22'h0, commut_angle});
		drive_angle = 10'h180;
		cyc(3);
		chk("angle at beta", 32'h100, {22'h0, commut_angle});
		wr(8'h6C, 32'd100);
		wr(8'h6D, 32'd1000);
		actual_speed = 32'd2000;
		cyc(3);
		chk("weakened angle", 32'h200, {22'h0, commut_angle});
		wr(8'h6E, 32'h80);
		cyc(3);
		chk("gamma capped", 32'h180, {22'h0, commut_angle});
		actual_speed = 32'h0;
		drive_angle = 10'h080;
		target_pos = 32'sd500;
		ramp_pos = 32'sd500;
		cyc(10);
		chk("outside window", 32'h0, {31'h0, target_reached});
		chk("catch up", 32'h1, {31'h0, catch_up});
		wr(8'hD4, 32'd100);
		cyc(10);
		chk("deviation stop", 32'h3, {30'h0, deviation_stop, motor_stop});
		target_pos = 32'sd0;
		ramp_pos = 32'sd0;
		wr(8'hD4, 32'h0);
		cyc(5);
		chk("deviation sticky", 32'h1, {31'h0, deviation_stop});
		wr(8'h81, 32'h1);
		cyc(2);
		chk("deviation cleared", 32'h0, {31'h0, motor_stop});
		$display("test closed loop done");
	endtask

	task automatic t_stall;
		wr(8'hB5, 32'd100);
		wr(8'hAE, 32'd10);
		actual_speed = 32'd50;
		load_value = 10'h000;
		cyc(20);
		chk("slow no stall", 32'h0, {31'h0, stall_stop});
		actual_speed = 32'd200;
		load_value = 10'h3FF;
		cyc(20);
		chk("light load", 32'h0, {31'h0, stall_stop});
		load_value = 10'h005;
		cyc(5);
		chk("stall stop", 32'h3, {30'h0, stall_stop, motor_stop});
		load_value = 10'h3FF;
		cyc(5);
		chk("stall sticky", 32'h1, {31'h0, stall_stop});
		wr(8'h81, 32'h1);
		cyc(2);
		chk("stall cleared", 32'h0, {31'h0, motor_stop});
		actual_speed = 32'h0;
		$display("test stall done");
	endtask

	// Half-scale load angle demands about half current; limits and delays shape it
	task automatic t_current;
		wr(8'h78, 32'h0);
		wr(8'h72, 32'h40);
		drive_angle = 10'h080;
		cyc(100);
		chk("current clamped", 32'h40, {24'h0, current_scale});
		drive_angle = 10'h000;
		cyc(20);
		chk("slow decrease", 32'h40, {24'h0, current_scale});
		wr(8'h79, 32'h0);
		wr(8'h71, 32'h10);
		cyc(100);
		chk("current floor", 32'h10, {24'h0, current_scale});
		$display("test current done");
	endtask

	initial
	begin
		cyc(6);
		rst_n = 1'b1;
		t_defaults;
		t_encoder;
		t_loop;
		t_stall;
		t_current;
		complete_run;
	end
endmodule

// *** src/cle_map.svh ***
// Axis parameter numbers, reset values and field widths of the closed-loop encoder block.
// Assumes the includer supplies the clock; definitions only.
`ifndef CLE_MAP_SVH
`define CLE_MAP_SVH
`define CLE_AP_GAMMA_VMIN 8'h6C
`define CLE_AP_GAMMA_VMAX 8'h6D
`define CLE_AP_GAMMA_MAX 8'h6E
`define CLE_AP_BETA 8'h6F
`define CLE_AP_CUR_MIN 8'h71
`define CLE_AP_CUR_MAX 8'h72
`define CLE_AP_UP_DELAY 8'h78
`define CLE_AP_DOWN_DELAY 8'h79
`define CLE_AP_CL_ENABLE 8'h81
`define CLE_AP_INIT_DONE 8'h85
`define CLE_AP_POS_WINDOW 8'h86
`define CLE_AP_STALL_LOAD 8'hAE
`define CLE_AP_STALL_SPEED 8'hB5
`define CLE_AP_FULL_STEPS 8'hCA
`define CLE_AP_ENC_POS 8'hD1
`define CLE_AP_ENC_RES 8'hD2
`define CLE_AP_MAX_DEV 8'hD4
`define CLE_RST_FULL_STEPS 32'h0000_00C8
`define CLE_RST_ENC_RES 32'h0000_0190
`define CLE_RST_BETA 32'h0000_00FF
`define CLE_RST_GAMMA_MAX 32'h0000_00FF
`define CLE_RST_CUR_MIN 32'h0000_0000
`define CLE_RST_CUR_MAX 32'h0000_00FF
`define CLE_RST_UP_DELAY 32'h0000_03E8
`define CLE_RST_DOWN_DELAY 32'h0000_2710
`define CLE_RST_POS_WINDOW 32'h0000_0064
`define CLE_MICROSTEPS 32'h0000_0100
`define CLE_INIT_CYCLES 16'h0400
`define CLE_ANGLE_W 10
`define CLE_ANGLE_90 10'h100
`define CLE_ANGLE_180 10'h200
`endif

// *** src/cle_pkg.sv ***
// Types shared by the closed-loop encoder block.
// No dependencies.
package cle_pkg;
	typedef enum logic [3:0]
	{
		CLE_OPEN = 4'h1,
		CLE_INIT = 4'h2,
		CLE_RUN = 4'h4,
		CLE_CATCH = 4'h8
	} cle_loop_type;
endpackage

// *** src/cle_quad.sv ***
// Quadrature decoder with a signed step accumulator.
// Assumes phase inputs already synchronous to ref_clk.
`timescale 1ns/10ps
`include "cle_map.svh"
module cle_quad
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic enc_a,
	input wire logic enc_b,
	output logic signed [31:0] count_out,
	output logic step_out,
	output logic dir_neg_out
);
	typedef struct packed
	{
		logic [1:0] ab;
		logic signed [31:0] count;
		logic step;
		logic neg;
	} cle_quad_state_type;
	cle_quad_state_type state_reg;
	cle_quad_state_type state_next;

	always_comb
	begin
		state_next = state_reg;
		state_next.ab = {enc_a, enc_b};
		state_next.step = 1'b0;
		// Direction from which phase leads; double changes are illegal and dropped
		if (({enc_a, enc_b} ^ state_reg.ab) == 2'b01 || ({enc_a, enc_b} ^ state_reg.ab) == 2'b10)
		begin
			state_next.step = 1'b1;
			state_next.neg = state_reg.ab[1] ^ enc_b;
			state_next.count = state_next.neg ? state_reg.count - 32'sh1 : state_reg.count + 32'sh1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign count_out = state_reg.count;
	assign step_out = state_reg.step;
	assign dir_neg_out = state_reg.neg;
endmodule

// *** src/cle_scale.sv ***
// Rescales raw encoder counts to microsteps by a running remainder (no divider).
// Each encoder step adds full_steps*256 to a remainder; whole encoder revolutions worth emit microsteps.
`timescale 1ns/10ps
`include "cle_map.svh"
module cle_scale
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic step_in,
	input wire logic neg_in,
	input wire logic [31:0] full_steps,
	input wire logic [31:0] enc_res,
	input wire logic load,
	input wire logic signed [31:0] load_value,
	output logic signed [31:0] pos_out
);
	typedef struct packed
	{
		logic [39:0] acc;
		logic [1:0] pend;
		logic neg;
		logic signed [31:0] pos;
	} cle_scale_state_type;
	cle_scale_state_type state_reg;
	cle_scale_state_type state_next;
	logic [39:0] inc;

	always_comb
	begin
		inc = {full_steps, 8'h00};
		state_next = state_reg;
		if (load)
		begin
			state_next.pos = load_value;
			state_next.acc = '0;
			state_next.pend = 2'b00;
		end
		else
		begin
			// Emit and accumulate in the same cycle so a step arriving mid-burst is not lost
			if (state_reg.acc >= {8'h00, enc_res} && enc_res != 32'h0)
			begin
				state_next.acc = state_reg.acc - {8'h00, enc_res};
				state_next.pos = state_reg.neg ? state_reg.pos - 32'sh1 : state_reg.pos + 32'sh1;
			end
			if (step_in)
			begin
				if (neg_in != state_reg.neg)
				begin
					// Limitation: a reversal discards what is left of the old direction
					state_next.acc = inc;
					state_next.neg = neg_in;
				end
				else
				begin
					state_next.acc = state_next.acc + inc;
				end
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign pos_out = state_reg.pos;
endmodule

// *** src/cle_top.sv ***
// Closed-loop encoder supervision for one axis: parameters, position, load angle, current, stall.
// Host drives set/get axis parameter strobes synchronous to ref_clk; encoder phases already synchronous.
`timescale 1ns/10ps
`include "cle_map.svh"
module cle_top
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic set_axis_parameter_cmd,
	input wire logic get_axis_parameter_cmd,
	input wire logic [7:0] param_num,
	input wire logic [31:0] param_wdata,
	input wire logic enc_a,
	input wire logic enc_b,
	input wire logic ref_search_done,
	input wire logic signed [31:0] target_pos,
	input wire logic signed [31:0] ramp_pos,
	input wire logic [31:0] actual_speed,
	input wire logic [9:0] drive_angle,
	input wire logic [9:0] rotor_angle,
	input wire logic [9:0] load_value,
	output logic [31:0] param_rdata,
	output logic param_rvalid,
	output logic motor_stop,
	output logic deviation_stop,
	output logic stall_stop,
	output logic target_reached,
	output logic catch_up,
	output logic init_done,
	output logic [9:0] commut_angle,
	output logic [7:0] current_scale
);
	typedef struct packed
	{
		cle_pkg::cle_loop_type loop;
		logic [15:0] init_cnt;
		logic [31:0] full_steps;
		logic [31:0] enc_res;
		logic [31:0] max_dev;
		logic [31:0] beta;
		logic [31:0] gamma_max;
		logic [31:0] gamma_vmin;
		logic [31:0] gamma_vmax;
		logic [7:0] cur_min;
		logic [7:0] cur_max;
		logic [31:0] up_delay;
		logic [31:0] down_delay;
		logic [31:0] pos_window;
		logic [9:0] stall_load;
		logic [31:0] stall_speed;
		logic [31:0] delay_cnt;
		logic [7:0] cur;
		logic [9:0] angle;
		logic [31:0] rdata;
		logic rvalid;
		logic dev_stop;
		logic stl_stop;
		logic reached;
		logic init_ok;
		logic stop;
		logic catching;
	} cle_top_state_type;
	cle_top_state_type state_reg;
	cle_top_state_type state_next;

	logic signed [31:0] raw_count;
	logic enc_step;
	logic enc_neg;
	logic signed [31:0] enc_pos;
	logic enc_load;
	logic signed [31:0] enc_load_value;
	logic [9:0] load_angle;
	logic [9:0] limit_angle;
	logic [9:0] gamma_angle;
	logic [7:0] cur_demand;
	logic [31:0] pos_err;
	logic [31:0] follow_err;

	function automatic logic [31:0] cle_abs_diff(input logic signed [31:0] a, input logic signed [31:0] b);
		logic signed [31:0] d;
		d = a - b;
		return d[31] ? 32'(-d) : 32'(d);
	endfunction

	function automatic logic [9:0] cle_sat_angle(input logic [31:0] v);
		return (v > 32'h3FF) ? 10'h3FF : v[9:0];
	endfunction

	cle_quad quad_inst
	(
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.enc_a(enc_a),
		.enc_b(enc_b),
		.count_out(raw_count),
		.step_out(enc_step),
		.dir_neg_out(enc_neg)
	);

	cle_scale scale_inst
	(
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.step_in(enc_step),
		.neg_in(enc_neg),
		.full_steps(state_reg.full_steps),
		.enc_res(state_reg.enc_res),
		.load(enc_load),
		.load_value(enc_load_value),
		.pos_out(enc_pos)
	);

	// Reference search zeroing wins over a host write in the same cycle
	always_comb
	begin
		enc_load = ref_search_done || (set_axis_parameter_cmd && param_num == `CLE_AP_ENC_POS);
		enc_load_value = ref_search_done ? 32'sh0 : $signed(param_wdata);
	end

	// Load angle, beta limit (255 maps to 90 degrees) and field weakening
	always_comb
	begin
		load_angle = drive_angle - rotor_angle;
		if (load_angle[9])
		begin
			load_angle = 10'(-load_angle);
		end
		limit_angle = cle_sat_angle((state_reg.beta * 32'(`CLE_ANGLE_90)) / 32'h0000_00FF);
		gamma_angle = limit_angle;
		if (actual_speed > state_reg.gamma_vmin && state_reg.gamma_vmax > state_reg.gamma_vmin)
		begin
			// Linear rise from beta toward 180 degrees, capped by gamma maximum
			if (actual_speed >= state_reg.gamma_vmax)
			begin
				gamma_angle = `CLE_ANGLE_180;
			end
			else
			begin
				gamma_angle = cle_sat_angle(32'(limit_angle) + (((actual_speed - state_reg.gamma_vmin) >> 8)
					* 32'(`CLE_ANGLE_90)) / (((state_reg.gamma_vmax - state_reg.gamma_vmin) >> 8) | 32'h1));
			end
			if (gamma_angle > cle_sat_angle(32'(`CLE_ANGLE_90) + ((state_reg.gamma_max * 32'(`CLE_ANGLE_90))
				/ 32'h0000_00FF)))
			begin
				gamma_angle = cle_sat_angle(32'(`CLE_ANGLE_90) + ((state_reg.gamma_max * 32'(`CLE_ANGLE_90))
					/ 32'h0000_00FF));
			end
		end
		// Demand scales with load angle over the beta span, clamped
		cur_demand = (limit_angle == 10'h0) ? state_reg.cur_max
			: 8'(((32'(load_angle) * 32'h0000_00FF) / 32'(limit_angle)) > 32'hFF ? 32'hFF
			: ((32'(load_angle) * 32'h0000_00FF) / 32'(limit_angle)));
		if (cur_demand < state_reg.cur_min)
		begin
			cur_demand = state_reg.cur_min;
		end
		if (cur_demand > state_reg.cur_max)
		begin
			cur_demand = state_reg.cur_max;
		end
		pos_err = cle_abs_diff(target_pos, enc_pos);
		follow_err = cle_abs_diff(ramp_pos, enc_pos);
	end

	always_comb
	begin
		state_next = state_reg;
		state_next.rvalid = 1'b0;
		if (set_axis_parameter_cmd)
		begin
			unique case (param_num)
				`CLE_AP_FULL_STEPS: state_next.full_steps = param_wdata;
				`CLE_AP_ENC_RES: state_next.enc_res = param_wdata;
				`CLE_AP_MAX_DEV: state_next.max_dev = param_wdata;
				`CLE_AP_BETA: state_next.beta = param_wdata;
				`CLE_AP_GAMMA_MAX: state_next.gamma_max = param_wdata;
				`CLE_AP_GAMMA_VMIN: state_next.gamma_vmin = param_wdata;
				`CLE_AP_GAMMA_VMAX: state_next.gamma_vmax = param_wdata;
				`CLE_AP_CUR_MIN: state_next.cur_min = param_wdata[7:0];
				`CLE_AP_CUR_MAX: state_next.cur_max = param_wdata[7:0];
				`CLE_AP_UP_DELAY: state_next.up_delay = param_wdata;
				`CLE_AP_DOWN_DELAY: state_next.down_delay = param_wdata;
				`CLE_AP_POS_WINDOW: state_next.pos_window = param_wdata;
				`CLE_AP_STALL_LOAD: state_next.stall_load = param_wdata[9:0];
				`CLE_AP_STALL_SPEED: state_next.stall_speed = param_wdata;
				`CLE_AP_CL_ENABLE:
				begin
					// Enabling restarts init unless the loop case below overrides it (INIT keeps counting); a fresh enable clears stops whose fault is gone
					state_next.loop = param_wdata[0] ? cle_pkg::CLE_INIT : cle_pkg::CLE_OPEN;
					state_next.init_cnt = 16'h0;
					state_next.init_ok = 1'b0;
					state_next.dev_stop = 1'b0;
					state_next.stl_stop = 1'b0;
				end
				default: ;
			endcase
		end
		if (get_axis_parameter_cmd)
		begin
			state_next.rvalid = 1'b1;
			unique case (param_num)
				`CLE_AP_FULL_STEPS: state_next.rdata = state_reg.full_steps;
				`CLE_AP_ENC_RES: state_next.rdata = state_reg.enc_res;
				`CLE_AP_ENC_POS: state_next.rdata = enc_pos;
				`CLE_AP_MAX_DEV: state_next.rdata = state_reg.max_dev;
				`CLE_AP_BETA: state_next.rdata = state_reg.beta;
				`CLE_AP_GAMMA_MAX: state_next.rdata = state_reg.gamma_max;
				`CLE_AP_GAMMA_VMIN: state_next.rdata = state_reg.gamma_vmin;
				`CLE_AP_GAMMA_VMAX: state_next.rdata = state_reg.gamma_vmax;
				`CLE_AP_CUR_MIN: state_next.rdata = {24'h0, state_reg.cur_min};
				`CLE_AP_CUR_MAX: state_next.rdata = {24'h0, state_reg.cur_max};
				`CLE_AP_UP_DELAY: state_next.rdata = state_reg.up_delay;
				`CLE_AP_DOWN_DELAY: state_next.rdata = state_reg.down_delay;
				`CLE_AP_POS_WINDOW: state_next.rdata = state_reg.pos_window;
				`CLE_AP_STALL_LOAD: state_next.rdata = {22'h0, state_reg.stall_load};
				`CLE_AP_STALL_SPEED: state_next.rdata = state_reg.stall_speed;
				`CLE_AP_CL_ENABLE: state_next.rdata = {31'h0, state_reg.loop != cle_pkg::CLE_OPEN};
				`CLE_AP_INIT_DONE: state_next.rdata = {31'h0, state_reg.init_ok};
				default: state_next.rdata = 32'h0;
			endcase
		end

		unique case (state_reg.loop)
			cle_pkg::CLE_OPEN: ;
			cle_pkg::CLE_INIT:
			begin
				state_next.init_cnt = state_reg.init_cnt + 16'h1;
				if (state_reg.init_cnt == `CLE_INIT_CYCLES)
				begin
					state_next.init_ok = 1'b1;
					state_next.loop = cle_pkg::CLE_RUN;
				end
			end
			cle_pkg::CLE_RUN:
			begin
				// Ramp lost to load: switch to catch-up until the error shrinks
				if (follow_err > state_reg.pos_window && !state_reg.dev_stop)
				begin
					state_next.loop = cle_pkg::CLE_CATCH;
				end
			end
			cle_pkg::CLE_CATCH:
			begin
				if (follow_err <= state_reg.pos_window)
				begin
					state_next.loop = cle_pkg::CLE_RUN;
				end
			end
			default: state_next.loop = cle_pkg::CLE_OPEN;
		endcase

		// Angle and current loops update every cycle, independent of the ramp
		if (state_reg.loop == cle_pkg::CLE_RUN || state_reg.loop == cle_pkg::CLE_CATCH)
		begin
			state_next.angle = (load_angle >= limit_angle) ? gamma_angle : load_angle;
		end
		else
		begin
			state_next.angle = `CLE_ANGLE_90;
		end
		if (cur_demand == state_reg.cur)
		begin
			state_next.delay_cnt = 32'h0;
		end
		else if (state_reg.delay_cnt >= ((cur_demand > state_reg.cur) ? state_reg.up_delay : state_reg.down_delay))
		begin
			state_next.delay_cnt = 32'h0;
			state_next.cur = (cur_demand > state_reg.cur) ? state_reg.cur + 8'h1 : state_reg.cur - 8'h1;
		end
		else
		begin
			state_next.delay_cnt = state_reg.delay_cnt + 32'h1;
		end

		state_next.reached = pos_err <= state_reg.pos_window;
		// Zero limit disables the deviation stop
		if (state_reg.max_dev != 32'h0 && follow_err > state_reg.max_dev)
		begin
			state_next.dev_stop = 1'b1;
		end
		// Low load value means high load; zero is full load
		if (state_reg.stall_speed != 32'h0 && actual_speed > state_reg.stall_speed
			&& load_value <= state_reg.stall_load)
		begin
			state_next.stl_stop = 1'b1;
		end
		// Registered copies so these outputs come straight from flops
		state_next.stop = state_next.dev_stop | state_next.stl_stop;
		state_next.catching = state_next.loop == cle_pkg::CLE_CATCH;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			state_reg <= '0;
			state_reg.loop <= cle_pkg::CLE_OPEN;
			state_reg.full_steps <= `CLE_RST_FULL_STEPS;
			state_reg.enc_res <= `CLE_RST_ENC_RES;
			state_reg.beta <= `CLE_RST_BETA;
			state_reg.gamma_max <= `CLE_RST_GAMMA_MAX;
			state_reg.cur_min <= 8'(`CLE_RST_CUR_MIN);
			state_reg.cur_max <= 8'(`CLE_RST_CUR_MAX);
			state_reg.up_delay <= `CLE_RST_UP_DELAY;
			state_reg.down_delay <= `CLE_RST_DOWN_DELAY;
			state_reg.pos_window <= `CLE_RST_POS_WINDOW;
			state_reg.angle <= `CLE_ANGLE_90;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign param_rdata = state_reg.rdata;
	assign param_rvalid = state_reg.rvalid;
	assign motor_stop = state_reg.stop;
	assign deviation_stop = state_reg.dev_stop;
	assign stall_stop = state_reg.stl_stop;
	assign target_reached = state_reg.reached;
	assign catch_up = state_reg.catching;
	assign init_done = state_reg.init_ok;
	assign commut_angle = state_reg.angle;
	assign current_scale = state_reg.cur;
endmodule
